// *** hw/awk_pkg.sv ***
// stop-mode auto wakeup block: shared constants, field layout and carriers
// assumes a single 100 MHz clock, synchronous resets and an apb master
//
// Overview of operation
// (RQ1) wake latch bit in port a is read-only
// (RQ2) status register bits 7-4 read zero
// (RQ3) pending flag set by key or wakeup, reset clears
// (RQ4) writing acknowledge 1 clears requests, reads zero
// (RQ5) mask bit 1 blocks interrupt requests
// (RQ6) wakeup enable bit gates wake latch setting
// (RQ7) oscillator bit selects bus clock or rc
// (RQ8) oscillator bit keeps clock source running in stop
// (RQ9) rate bit picks 512 or 16384 wakeup cycles
// (RQ10) rate bit picks watchdog 8176 or 262128 cycles
// (RQ11) recovery bit picks 32 or 4096 exit cycles
// (RQ12) configuration registers write once, always readable
// (RQ13) configuration registers at indices 1E and 1F
// (RQ14) software writes configuration right after reset
// (RQ15) reset pin bit cleared by power-on only
// (RQ16) second configuration holds irq and serial controls
// (RQ17) wakeup counter restarts at zero each stop
// (RQ18) wakeup counter idle outside stop mode
// (RQ19) wake latch shows at port a bit 6
// (RQ20) wake latch cleared by reset and acknowledge
// (RQ21) interrupt request while flag set and unmasked

package awk_pkg;

    // -------------------------------------------------------------
    // register indices (byte address is four times the index)
    // -------------------------------------------------------------
    localparam int unsigned ADDR_W     = 8;
    localparam logic [5:0]  IDX_PORT_A = 6'h00;
    localparam logic [5:0]  IDX_KEY_SC = 6'h1A;
    localparam logic [5:0]  IDX_KEY_IE = 6'h1B;
    localparam logic [5:0]  IDX_CFG2   = 6'h1E;
    localparam logic [5:0]  IDX_CFG1   = 6'h1F;

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int unsigned POS_WAKE_LATCH   = 6;
    localparam int unsigned POS_PEND_FLAG    = 3;
    localparam int unsigned POS_ACK          = 2;
    localparam int unsigned POS_IRQ_MASK     = 1;
    localparam int unsigned POS_KEY_MODE     = 0;
    localparam int unsigned POS_WAKE_IRQ_EN  = 6;
    localparam int unsigned POS_IRQ_PULLUP   = 7;
    localparam int unsigned POS_IRQ_PIN_EN   = 6;
    localparam int unsigned POS_SERIAL_CLK   = 3;
    localparam int unsigned POS_OSC_IN_STOP  = 1;
    localparam int unsigned POS_RESET_PIN_EN = 0;
    localparam int unsigned POS_RATE_SELECT  = 7;
    localparam int unsigned POS_SHORT_RECOV  = 2;

    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [7:0] RST_CFG1   = 8'h00;
    localparam logic [7:0] RST_CFG2   = 8'h00;
    localparam logic [5:0] RST_KEY_IE = 6'h00;

    // -------------------------------------------------------------
    // cycle counts
    // -------------------------------------------------------------
    localparam int unsigned WAKE_SHORT_CYCLES = 512;
    localparam int unsigned WAKE_LONG_CYCLES  = 16384;
    localparam int unsigned COP_SHORT_CYCLES  = 8176;
    localparam int unsigned COP_LONG_CYCLES   = 262128;
    localparam int unsigned RECOV_SHORT_CYC   = 32;
    localparam int unsigned RECOV_LONG_CYC    = 4096;
    localparam int unsigned COP_W             = 18;
    localparam int unsigned RECOV_W           = 13;

    // -------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic               irq_pullup_disconnect;
        logic               irq_pin_function_enable;
        logic               serial_baud_clock_select;
        logic               reset_pin_function_enable;
        logic               osc_run_in_stop;
        logic               period_rate_select;
        logic               short_stop_recovery;
        logic [COP_W-1:0]   cop_period;
        logic [RECOV_W-1:0] stop_exit_delay;
        logic [7:0]         option_config_first;
        logic [7:0]         option_config_second;
    } awk_cfg_s;

    typedef struct packed {
        logic wake_rc_oscillator_enable;
        logic clock_source_enable;
        logic bus_clock_twice_rate_sel;
    } awk_clk_s;

endpackage

// *** hw/awk_wake_counter.sv ***
// wakeup overflow counter for stop mode
// assumes tick_i is a one-cycle enable per edge of the selected slow clock

module awk_wake_counter #(
    parameter int unsigned SHORT_CYCLES = awk_pkg::WAKE_SHORT_CYCLES,
    parameter int unsigned LONG_CYCLES  = awk_pkg::WAKE_LONG_CYCLES,
    parameter int unsigned CNT_W        = $clog2(LONG_CYCLES)
) (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic run_i,
    input  wire logic tick_i,
    input  wire logic short_sel_i,
    output logic      overflow_o
);

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             overflow;
    } awk_cnt_s;

    localparam logic [CNT_W-1:0] LAST_SHORT = CNT_W'(SHORT_CYCLES - 1);
    localparam logic [CNT_W-1:0] LAST_LONG  = CNT_W'(LONG_CYCLES - 1);

    awk_cnt_s state_q;
    awk_cnt_s state_d;
    logic [CNT_W-1:0] last_count;

    assign last_count = short_sel_i ? LAST_SHORT : LAST_LONG; // [RQ9]

    // count selected clock edges, pulse and wrap at the overflow count
    always_comb begin
        state_d          = state_q;
        state_d.overflow = 1'b0;
        if (reset_i || !run_i) begin
            state_d.count = '0; // [RQ17] [RQ18]
        end else if (tick_i) begin
            if (state_q.count >= last_count) begin
                state_d.count    = '0;
                state_d.overflow = 1'b1; // [RQ9]
            end else begin
                state_d.count = state_q.count + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        state_q <= state_d;
    end

    assign overflow_o = state_q.overflow;

endmodule

// *** hw/awk_stop_wakeup.sv ***
// stop-mode auto wakeup timer with its register view over apb
// assumes the cpu drives stop_mode_i, por_i comes with reset_i at power-up,
// and slow clock edges arrive as one-cycle ticks in this clock domain

module awk_stop_wakeup #(
    parameter int unsigned WAKE_LONG_CYCLES = awk_pkg::WAKE_LONG_CYCLES,
    parameter int unsigned COP_LONG_CYCLES  = awk_pkg::COP_LONG_CYCLES
) (
    input  wire logic                       clk_i,
    input  wire logic                       reset_i,
    input  wire logic                       por_i,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [awk_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       stop_mode_i,
    input  wire logic                       wake_rc_tick_i,
    input  wire logic                       bus_clock_twice_rate_tick_i,
    input  wire logic                       key_request_i,
    output logic                            wake_irq_o,
    output logic                            wake_latch_status_o,
    output awk_pkg::awk_clk_s               clk_ctrl_o,
    output awk_pkg::awk_cfg_s               cfg_o
);

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  cfg1;
        logic [7:0]  cfg2;
        logic        cfg1_done;
        logic        cfg2_done;
        logic        wake_latch;
        logic        key_latch;
        logic        irq_mask;
        logic        key_mode;
        logic        wake_irq_en;
        logic [5:0]  key_irq_en;
        logic [31:0] rdata;
        logic        wake_irq;
    } awk_state_s;

    awk_state_s state_q;
    awk_state_s state_d;

    logic [5:0] index;
    logic       hit_port_a;
    logic       hit_key_sc;
    logic       hit_key_ie;
    logic       hit_cfg2;
    logic       hit_cfg1;
    logic       mapped;
    logic       setup;
    logic       wr_access;
    logic       ack_write;
    logic       pend_flag;
    logic       osc_in_stop;
    logic       rate_short;
    logic       slow_tick;
    logic       wake_overflow;
    logic [7:0] port_a_view;
    logic [7:0] key_sc_view;
    logic [7:0] key_ie_view;
    logic [7:0] read_byte;

    // -------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------

    // word index from the byte address
    assign index      = paddr[7:2];
    assign hit_port_a = (index == awk_pkg::IDX_PORT_A);
    assign hit_key_sc = (index == awk_pkg::IDX_KEY_SC);
    assign hit_key_ie = (index == awk_pkg::IDX_KEY_IE);
    assign hit_cfg2   = (index == awk_pkg::IDX_CFG2);  // [RQ13]
    assign hit_cfg1   = (index == awk_pkg::IDX_CFG1);  // [RQ13]
    assign mapped     = hit_port_a | hit_key_sc | hit_key_ie
                      | hit_cfg2 | hit_cfg1;
    assign setup      = psel & ~penable;
    assign wr_access  = psel & penable & pwrite & mapped;
    assign ack_write  = wr_access & hit_key_sc
                      & pwdata[awk_pkg::POS_ACK];        // [RQ4]

    // -------------------------------------------------------------
    // wakeup clock and counter
    // -------------------------------------------------------------

    // selected slow clock drives the counter only in stop
    assign osc_in_stop = state_q.cfg2[awk_pkg::POS_OSC_IN_STOP];
    assign rate_short  = state_q.cfg1[awk_pkg::POS_RATE_SELECT];
    assign slow_tick   = osc_in_stop ? bus_clock_twice_rate_tick_i
                                     : wake_rc_tick_i;  // [RQ7]

    awk_wake_counter #(
        .SHORT_CYCLES (awk_pkg::WAKE_SHORT_CYCLES),
        .LONG_CYCLES  (WAKE_LONG_CYCLES),
        .CNT_W        ($clog2(WAKE_LONG_CYCLES))
    ) u_wake_counter (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .run_i        (stop_mode_i),  // [RQ18]
        .tick_i       (slow_tick),
        .short_sel_i  (rate_short),
        .overflow_o   (wake_overflow)
    );

    // -------------------------------------------------------------
    // read views
    // -------------------------------------------------------------

    // keyboard flag is the or of both request latches
    assign pend_flag = state_q.wake_latch | state_q.key_latch; // [RQ3]

    // port a shows only the wake latch, other bits read zero
    always_comb begin
        port_a_view = 8'h00;
        port_a_view[awk_pkg::POS_WAKE_LATCH] = state_q.wake_latch; // [RQ19]
    end

    // status view: upper nibble zero, acknowledge reads zero
    always_comb begin
        key_sc_view = 8'h00;                                  // [RQ2]
        key_sc_view[awk_pkg::POS_PEND_FLAG] = pend_flag;
        key_sc_view[awk_pkg::POS_ACK]       = 1'b0;           // [RQ4]
        key_sc_view[awk_pkg::POS_IRQ_MASK]  = state_q.irq_mask;
        key_sc_view[awk_pkg::POS_KEY_MODE]  = state_q.key_mode;
    end

    // enable view: wakeup enable plus stored key enables
    always_comb begin
        key_ie_view = {2'b00, state_q.key_irq_en};
        key_ie_view[awk_pkg::POS_WAKE_IRQ_EN] = state_q.wake_irq_en;
    end

    // read multiplexer, unmapped reads return zero
    always_comb begin
        read_byte = 8'h00;
        if (hit_port_a) begin
            read_byte = port_a_view;
        end else if (hit_key_sc) begin
            read_byte = key_sc_view;
        end else if (hit_key_ie) begin
            read_byte = key_ie_view;
        end else if (hit_cfg2) begin
            read_byte = state_q.cfg2;  // [RQ12]
        end else if (hit_cfg1) begin
            read_byte = state_q.cfg1;  // [RQ12]
        end
    end

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        state_d = state_q;

        // read data captured in the setup cycle
        if (setup) begin
            state_d.rdata = {24'h000000, read_byte};
        end

        // status and enable writes
        if (wr_access && hit_key_sc) begin
            state_d.irq_mask = pwdata[awk_pkg::POS_IRQ_MASK]; // [RQ5]
            state_d.key_mode = pwdata[awk_pkg::POS_KEY_MODE];
        end
        if (wr_access && hit_key_ie) begin
            state_d.wake_irq_en = pwdata[awk_pkg::POS_WAKE_IRQ_EN]; // [RQ6]
            state_d.key_irq_en  = pwdata[5:0];
        end

        // configuration registers accept the first write only
        if (wr_access && hit_cfg2 && !state_q.cfg2_done) begin
            state_d.cfg2      = pwdata[7:0];  // [RQ12] [RQ16]
            state_d.cfg2_done = 1'b1;         // [RQ12]
        end
        if (wr_access && hit_cfg1 && !state_q.cfg1_done) begin
            state_d.cfg1      = pwdata[7:0];  // [RQ12]
            state_d.cfg1_done = 1'b1;         // [RQ12]
        end

        // request latches: acknowledge clears, a new event wins
        if (ack_write) begin
            state_d.wake_latch = 1'b0;  // [RQ4] [RQ20]
            state_d.key_latch  = 1'b0;  // [RQ4]
        end
        if (wake_overflow && state_q.wake_irq_en) begin
            state_d.wake_latch = 1'b1;  // [RQ6]
        end
        if (key_request_i) begin
            state_d.key_latch = 1'b1;   // [RQ3]
        end

        // request toward the cpu, registered
        state_d.wake_irq = (state_d.wake_latch | state_d.key_latch)
                         & ~state_d.irq_mask;  // [RQ5] [RQ21]

        // synchronous reset; reset pin bit survives all but power-on
        if (reset_i) begin
            state_d             = '0;  // [RQ3] [RQ4] [RQ20]
            state_d.cfg1        = awk_pkg::RST_CFG1;
            state_d.cfg2        = awk_pkg::RST_CFG2;
            state_d.key_irq_en  = awk_pkg::RST_KEY_IE;
            state_d.cfg2[awk_pkg::POS_RESET_PIN_EN] =
                por_i ? 1'b0
                      : state_q.cfg2[awk_pkg::POS_RESET_PIN_EN]; // [RQ15]
        end
    end

    always_ff @(posedge clk_i) begin
        state_q <= state_d;
    end

    // -------------------------------------------------------------
    // bus answers
    // -------------------------------------------------------------

    // zero wait states, error on unmapped access
    assign prdata  = state_q.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign wake_irq_o          = state_q.wake_irq;    // [RQ21]
    assign wake_latch_status_o = state_q.wake_latch;  // [RQ1]

    // clock source keeps running in stop only when asked to
    assign clk_ctrl_o.clock_source_enable =
        ~stop_mode_i | osc_in_stop;                   // [RQ8]
    assign clk_ctrl_o.wake_rc_oscillator_enable =
        stop_mode_i & ~osc_in_stop;                   // [RQ7] [RQ18]
    assign clk_ctrl_o.bus_clock_twice_rate_sel = osc_in_stop; // [RQ7]

    // stored option bits and derived periods
    assign cfg_o.irq_pullup_disconnect =
        state_q.cfg2[awk_pkg::POS_IRQ_PULLUP];        // [RQ16]
    assign cfg_o.irq_pin_function_enable =
        state_q.cfg2[awk_pkg::POS_IRQ_PIN_EN];        // [RQ16]
    assign cfg_o.serial_baud_clock_select =
        state_q.cfg2[awk_pkg::POS_SERIAL_CLK];        // [RQ16]
    assign cfg_o.reset_pin_function_enable =
        state_q.cfg2[awk_pkg::POS_RESET_PIN_EN];      // [RQ15]
    assign cfg_o.osc_run_in_stop    = osc_in_stop;
    assign cfg_o.period_rate_select = rate_short;
    assign cfg_o.short_stop_recovery =
        state_q.cfg1[awk_pkg::POS_SHORT_RECOV];
    assign cfg_o.cop_period = rate_short
        ? awk_pkg::COP_W'(awk_pkg::COP_SHORT_CYCLES)
        : awk_pkg::COP_W'(COP_LONG_CYCLES);           // [RQ10]
    assign cfg_o.stop_exit_delay =
        state_q.cfg1[awk_pkg::POS_SHORT_RECOV]
        ? awk_pkg::RECOV_W'(awk_pkg::RECOV_SHORT_CYC)
        : awk_pkg::RECOV_W'(awk_pkg::RECOV_LONG_CYC); // [RQ11]
    assign cfg_o.option_config_first  = state_q.cfg1;
    assign cfg_o.option_config_second = state_q.cfg2;

endmodule

// *** tb/awk_stop_wakeup_assertions.sv ***
// checker for the stop-mode wakeup block, watching its ports only
// assumes one clock with a synchronous active-high reset
module awk_stop_wakeup_assertions #(
    parameter int unsigned COP_LONG_CYCLES = 262128
) (
    input wire logic              clk_i,
    input wire logic              reset_i,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              stop_mode_i,
    input wire logic              key_request_i,
    input wire logic              wake_irq_o,
    input wire logic              wake_latch_status_o,
    input wire awk_pkg::awk_clk_s clk_ctrl_o,
    input wire awk_pkg::awk_cfg_s cfg_o
);
    timeunit 1ns / 1ps;
    // ----
    // helper decode
    // ----
    logic [5:0] idx;
    logic       setup;
    logic       wr_acc;
    logic       cfg1_done_q;
    assign idx    = paddr[7:2];
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;

    // remembers that the first cfg1 write since reset has landed
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg1_done_q <= 1'b0;
        end else if (wr_acc && idx == awk_pkg::IDX_CFG1) begin
            cfg1_done_q <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // ----
    // assertions
    // ----
    AST_CLK_RC: assert property (
        clk_ctrl_o.wake_rc_oscillator_enable ==
        (stop_mode_i && !cfg_o.osc_run_in_stop))
        else $error("rc oscillator enable wrong");
    AST_CLK_SRC: assert property (
        clk_ctrl_o.clock_source_enable ==
        (!stop_mode_i || cfg_o.osc_run_in_stop))
        else $error("clock source enable wrong");
    AST_COP_PERIOD: assert property (
        cfg_o.cop_period == (cfg_o.period_rate_select ? 18'h01FF0 :
        18'(COP_LONG_CYCLES)))
        else $error("watchdog period wrong");
    AST_RECOVERY: assert property (
        cfg_o.stop_exit_delay ==
        (cfg_o.short_stop_recovery ? 13'h0020 : 13'h1000))
        else $error("stop exit delay wrong");
    AST_WAKE_IN_STOP: assert property (
        !stop_mode_i [*4] |-> !$rose(wake_latch_status_o))
        else $error("wake latch rose outside stop");
    AST_PORTA_LATCH: assert property (
        setup && idx == awk_pkg::IDX_PORT_A |=>
        prdata[6] == $past(wake_latch_status_o))
        else $error("port a bit 6 not the wake latch");
    AST_STATUS_ZERO: assert property (
        setup && idx == awk_pkg::IDX_KEY_SC |=>
        prdata[7:4] == 4'h0 && prdata[2] == 1'b0)
        else $error("status unused or ack bit read nonzero");
    AST_ACK_CLEARS: assert property (
        !stop_mode_i [*4] ##0 (wr_acc && idx == awk_pkg::IDX_KEY_SC &&
        pwdata[2] && !key_request_i) |=>
        !wake_latch_status_o && !wake_irq_o)
        else $error("acknowledge did not clear request");
    AST_CFG_ONCE: assert property (
        cfg1_done_q |=> $stable(cfg_o.option_config_first))
        else $error("config changed after first write");
    AST_CFG_DECODE: assert property (
        psel && penable &&
        (idx == awk_pkg::IDX_CFG1 || idx == awk_pkg::IDX_CFG2) |->
        pready && !pslverr)
        else $error("config address not decoded");

    // main scenarios seen
    COV_WAKE: cover property ($rose(wake_latch_status_o));
    COV_KEY: cover property (wake_irq_o && !wake_latch_status_o);
    COV_ERR: cover property (pslverr);
endmodule

bind awk_stop_wakeup awk_stop_wakeup_assertions #(
    .COP_LONG_CYCLES(COP_LONG_CYCLES)
) u_awk_stop_wakeup_assertions (
    .clk_i, .reset_i, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .stop_mode_i, .key_request_i,
    .wake_irq_o, .wake_latch_status_o, .clk_ctrl_o, .cfg_o
);

// *** tb/awk_far_model.sv ***
// far side model: stop mode level, slow clock ticks and key requests
// assumes the bench drives its requests right after rising edges
module awk_far_model (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic stop_req_i,
    input  wire logic key_req_i,
    output logic      stop_mode_o,
    output logic      rc_tick_o,
    output logic      bus_tick_o,
    output logic      key_o
);
    timeunit 1ns / 1ps;
    logic [1:0] rc_q;
    logic [1:0] bus_q;

    // rc oscillator runs only in stop, bus clock divider runs free
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            {stop_mode_o, key_o, rc_q, bus_q} <= '0;
        end else begin
            stop_mode_o <= stop_req_i;
            key_o       <= key_req_i;
            rc_q        <= stop_mode_o ? rc_q + 2'h1 : 2'h0;
            bus_q       <= (bus_q == 2'h2) ? 2'h0 : bus_q + 2'h1;
        end
    end
    assign rc_tick_o  = stop_mode_o && rc_q == 2'h3; // one in four
    assign bus_tick_o = bus_q == 2'h2;               // one in three
endmodule

// *** tb/awk_stop_wakeup_tb_top.sv ***
// bench for the stop-mode wakeup block with a far side model
// assumes the package, design, model and checker are compiled first
module awk_stop_wakeup_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned WL = 1024;
    logic clk_i = 1'b0, reset_i = 1'b1, por_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, stop_req = 1'b0, key_req = 1'b0;
    logic stop_mode, rc_tick, bus_tick, key_pulse, wake_irq, wake_latch;
    awk_pkg::awk_clk_s clk_ctrl;
    awk_pkg::awk_cfg_s cfg;
    int fail_count = 0, num_checks = 0;

    awk_stop_wakeup #(.WAKE_LONG_CYCLES(WL)) u_awk_stop_wakeup (
        .clk_i, .reset_i, .por_i, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .stop_mode_i(stop_mode),
        .wake_rc_tick_i(rc_tick), .bus_clock_twice_rate_tick_i(bus_tick),
        .key_request_i(key_pulse), .wake_irq_o(wake_irq),
        .wake_latch_status_o(wake_latch), .clk_ctrl_o(clk_ctrl),
        .cfg_o(cfg));
    awk_far_model u_awk_far_model (.clk_i, .reset_i,
        .stop_req_i(stop_req), .key_req_i(key_req), .stop_mode_o(stop_mode),
        .rc_tick_o(rc_tick), .bus_tick_o(bus_tick), .key_o(key_pulse));

    always #5 clk_i = ~clk_i;

    // ----
    // shared tasks
    // ----
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [5:0] idx,
        input logic [7:0] wd, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_i);
        {psel, penable, pwrite} <= {1'b1, 1'b0, wr};
        paddr  <= {idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) chk("pready", 32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rd_chk(input string nm, input logic [5:0] idx,
        input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
        chk(nm, r, exp);
    endtask

    task automatic rst(input logic por);
        @(posedge clk_i);
        {reset_i, por_i} <= {1'b1, por};
        @(posedge clk_i);
        {reset_i, por_i} <= 2'h0;
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_config;
        logic [31:0] r;
        logic e;
        rst(1'b1);
        rd_chk("cfg1_rst", awk_pkg::IDX_CFG1, 32'h0);
        rd_chk("key_ie_rst", awk_pkg::IDX_KEY_IE, 32'h0);
        rd_chk("key_sc_rst", awk_pkg::IDX_KEY_SC, 32'h0);
        wr(awk_pkg::IDX_CFG1, 8'h84);
        wr(awk_pkg::IDX_CFG2, 8'hCB);
        wr(awk_pkg::IDX_CFG1, 8'h00);
        wr(awk_pkg::IDX_CFG2, 8'h00);
        rd_chk("cfg1_once", awk_pkg::IDX_CFG1, 32'h84);
        rd_chk("cfg2_once", awk_pkg::IDX_CFG2, 32'hCB);
        chk("cop_short", 32'(cfg.cop_period), 32'h1FF0);
        chk("recov_short", 32'(cfg.stop_exit_delay), 32'h20);
        chk("cfg2_bits", 32'({cfg.irq_pullup_disconnect,
            cfg.irq_pin_function_enable, cfg.serial_baud_clock_select,
            cfg.reset_pin_function_enable}), 32'hF);
        rst(1'b0);
        rd_chk("cfg2_warm", awk_pkg::IDX_CFG2, 32'h01);
        chk("cop_long", 32'(cfg.cop_period), 32'h3FFF0);
        chk("recov_long", 32'(cfg.stop_exit_delay), 32'h1000);
        rst(1'b1);
        rd_chk("cfg2_cold", awk_pkg::IDX_CFG2, 32'h0);
        apb(1'b0, 6'h05, 8'h00, r, e);
        chk("unmapped", {r[30:0], e}, 32'h1);
        $display("config test done");
    endtask

    task automatic t_keys;
        rst(1'b1);
        @(posedge clk_i);
        key_req <= 1'b1;
        @(posedge clk_i);
        key_req <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("key_irq", 32'(wake_irq), 32'h1);
        rd_chk("key_flag", awk_pkg::IDX_KEY_SC, 32'h08);
        wr(awk_pkg::IDX_KEY_SC, 8'h02);
        @(posedge clk_i);
        chk("key_masked", 32'(wake_irq), 32'h0);
        wr(awk_pkg::IDX_KEY_SC, 8'hF6);
        rd_chk("key_ack", awk_pkg::IDX_KEY_SC, 32'h02);
        $display("key test done");
    endtask

    // wakeup period from a fresh stop entry, for one setting
    task automatic t_wake(input logic rate, osc, en, mask);
        int cnt;
        int exp_n;
        cnt = 0;
        exp_n = rate ? 512 : WL;
        rst(1'b1);
        wr(awk_pkg::IDX_CFG1, {rate, 7'h0});
        wr(awk_pkg::IDX_CFG2, {6'h0, osc, 1'b0});
        wr(awk_pkg::IDX_KEY_IE, {1'b0, en, 6'h0});
        wr(awk_pkg::IDX_KEY_SC, {6'h0, mask, 1'b0});
        stop_req <= 1'b1;
        repeat (300) @(posedge clk_i);
        stop_req <= 1'b0;
        repeat (4) @(posedge clk_i);
        stop_req <= 1'b1;
        while (cnt < exp_n + 2) begin
            @(posedge clk_i);
            if (wake_latch === 1'b1) break;
            if (stop_mode && (osc ? bus_tick : rc_tick)) cnt++;
        end
        chk("ticks", cnt, en ? exp_n : exp_n + 2);
        chk("clk_ctrl", 32'(clk_ctrl), {29'h0, !osc, osc, osc});
        chk("irq", 32'(wake_irq), 32'(en & !mask));
        rd_chk("port_a", awk_pkg::IDX_PORT_A, {25'h0, en, 6'h0});
        rd_chk("status", awk_pkg::IDX_KEY_SC,
            {28'h0, en, 1'b0, mask, 1'b0});
        stop_req <= 1'b0;
        repeat (4) @(posedge clk_i);
        wr(awk_pkg::IDX_KEY_SC, {5'h0, 1'b1, mask, 1'b0});
        @(posedge clk_i);
        chk("latch_ack", 32'(wake_latch), 32'h0);
        chk("irq_ack", 32'(wake_irq), 32'h0);
        $display("wake test done rate %0d osc %0d", rate, osc);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        {reset_i, por_i} <= 2'h0;
        t_config;
        t_keys;
        t_wake(1'b1, 1'b0, 1'b1, 1'b0);
        t_wake(1'b0, 1'b1, 1'b1, 1'b1);
        t_wake(1'b1, 1'b1, 1'b0, 1'b0);
        results;
    end

    // watchdog
    initial begin
        #400000;
        fail_count++;
        results;
    end
endmodule
